// [bench/tb_csd_dispatch.sv]
/* Self-checking testbench for csd_dispatch: an integer model of the active and
   written machine state predicts every dispatch and exception.
   Assumes the package csd_pkg and the design module csd_dispatch are compiled first. */
`timescale 1ns/100ps
module tb_csd_dispatch;
   import csd_pkg::*;
   logic        sys_clk, srst, issue_valid, issue_trap_cond, hi_irq_pend, done_valid;
   logic        done_page_fault, done_align_fault, done_dstore_err, done_fp_exc;
   logic [31:0] issue_word, issue_operand, exec_word, r;
   logic        issue_ready, exec_valid, exc_valid, flush, user_mode_bit;
   logic [2:0]  machine_state_reg, m_wr, m_sv;
   logic        m_user, m_fp, m_fe;
   csd_cause_t  exc_cause;
   int          mismatches = 0;
   int          num_checks = 0;
   logic [9:0]  pxo [11] = '{XO_ICBT, XO_DCBI, XO_MFMSR, XO_MTMSR, XO_MFSR, XO_MFSRIN,
                             XO_MTSRIN, XO_TLBIE, XO_TLBSYNC, XO_TLBLD, XO_TLBLI};
   logic [3:0]  fl [4] = '{4'h8, 4'h4, 4'h2, 4'hC};
   csd_cause_t  fc [4] = '{CS_ISF, CS_ALIGN, CS_DSTORE, CS_ISF};
   csd_dispatch csd_dispatch_inst (.sys_clk, .srst, .issue_valid, .issue_word, .issue_operand,
      .issue_trap_cond, .hi_irq_pend, .done_valid, .done_page_fault, .done_align_fault,
      .done_dstore_err, .done_fp_exc, .issue_ready, .exec_valid, .exec_word, .exc_valid,
      .exc_cause, .flush, .user_mode_bit, .machine_state_reg);
   function automatic logic [31:0] wx(input logic [5:0] op, input logic [9:0] xo);
      return {op, 15'h0000, xo, 1'b0};
   endfunction : wx
   // Expected cause of an issued word under the model's active context
   function automatic csd_cause_t exp_cause(input logic [31:0] w, input logic tc);
      logic [5:0] op;
      logic [9:0] xo;
      logic       sup;
      op  = w[31:26];
      xo  = w[10:1];
      sup = (op == OP_GRP31 && (xo inside {pxo} || (xo inside {XO_MFSPR, XO_MTSPR} && w[20])))
            || (op == OP_GRP19 && xo == XO_RFI);
      if (w == 32'h0000_0000 || OP_ILL_MASK[op]) return CS_ILLEGAL;
      if (m_user && sup) return CS_PRIV;
      if (op == OP_SYSC) return CS_SYSCALL;
      if ((op == OP_TRAPI || (op == OP_GRP31 && xo == XO_TW)) && tc) return CS_TRAP;
      if ((op inside {[OP_FLS_LO:OP_FLS_HI], OP_FPS, OP_FPD}) && !(m_fp && FP_PRESENT))
         return CS_FP_UNAVAIL;
      return CS_NONE;
   endfunction : exp_cause
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run
   task automatic tmo(input string nm);
      mismatches++;
      $display("[FAIL] %s expected event seen timeout", nm);
      complete_run();
   endtask : tmo
   task automatic offer(input logic [31:0] w, input logic [31:0] opnd, input logic tc);
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (issue_ready !== 1'b1 && n < 80);
      if (issue_ready !== 1'b1) tmo("issue_ready");
      @(posedge sys_clk);
      issue_valid     <= 1'b1;
      issue_word      <= w;
      issue_operand   <= opnd;
      issue_trap_cond <= tc;
      @(posedge sys_clk);
      issue_valid <= 1'b0;
   endtask : offer
   task automatic done_pulse(input logic [3:0] f);
      @(posedge sys_clk);
      done_valid <= 1'b1;
      {done_page_fault, done_align_fault, done_dstore_err, done_fp_exc} <= f;
      @(posedge sys_clk);
      done_valid <= 1'b0;
      {done_page_fault, done_align_fault, done_dstore_err, done_fp_exc} <= 4'h0;
   endtask : done_pulse
   task automatic quiet(input int n);
      repeat (n) begin
         @(negedge sys_clk);
         chk("no_output", {exec_valid, exc_valid}, 2'b00);
      end
   endtask : quiet
   task automatic result(input logic [31:0] w, input csd_cause_t ec, input int bound);
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (exec_valid !== 1'b1 && exc_valid !== 1'b1 && n < bound);
      if (exec_valid !== 1'b1 && exc_valid !== 1'b1) tmo("result");
      chk("exc_valid", exc_valid, ec != CS_NONE);
      if (ec != CS_NONE) begin
         chk("exc_cause", exc_cause, ec);
         chk("flush", flush, 1'b1);
         // Entry saves the written state, leaves user mode and runs in it
         m_sv                 = m_wr;
         m_wr[M_PR]           = 1'b0;
         {m_user, m_fp, m_fe} = m_wr;
      end else begin
         chk("exec_word", exec_word, w);
         if (w == wx(OP_GRP19, XO_RFI)) begin
            m_wr                 = m_sv;
            {m_user, m_fp, m_fe} = m_sv;
         end
         if (w == wx(OP_GRP19, XO_ISYNC)) {m_user, m_fp, m_fe} = m_wr;
         if (w == wx(OP_GRP31, XO_MTMSR))
            m_wr = {issue_operand[OPND_PR_POS], issue_operand[OPND_FP_POS],
                    issue_operand[OPND_FE0_POS] | issue_operand[OPND_FE1_POS]};
      end
   endtask : result
   task automatic step(input logic [31:0] w, input logic [31:0] opnd, input logic tc,
                       input logic keep);
      csd_cause_t ec;
      ec = exp_cause(w, tc);
      offer(w, opnd, tc);
      result(w, ec, 80);
      if (ec == CS_NONE && !keep) done_pulse(4'h0);
      repeat (2) @(negedge sys_clk);
      chk("user_mode_bit", user_mode_bit, m_user);
      chk("machine_state_reg", machine_state_reg, m_wr);
   endtask : step
   function automatic logic [31:0] plain();
      return {6'h0E, 26'($urandom())};
   endfunction : plain
   task automatic end_test(input string nm);
      $display("test %s finished, checks %0d mismatches %0d", nm, num_checks, mismatches);
   endtask : end_test
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      {srst, issue_valid, issue_trap_cond, hi_irq_pend, done_valid} = 5'b10000;
      {done_page_fault, done_align_fault, done_dstore_err, done_fp_exc} = 4'h0;
      {issue_word, issue_operand} = 64'h0;
      {m_user, m_fp, m_fe, m_wr, m_sv} = 9'h000;
      void'($urandom(32'hD402E749));
      repeat (2) @(negedge sys_clk);
      chk("reset_ready", {issue_ready, exc_cause, user_mode_bit, machine_state_reg}, 9'h000);
      @(posedge sys_clk);
      srst <= 1'b0;
      repeat (4) step(plain(), $urandom(), 1'b0, 1'b0);
      end_test("plain");
      // Every unassigned primary opcode plus the all-zero word
      for (int op = 0; op < 64; op++) begin
         if (OP_ILL_MASK[op]) step({6'(op), 26'($urandom())}, $urandom(), 1'b0, 1'b0);
      end
      step(32'h0000_0000, $urandom(), 1'b0, 1'b0);
      end_test("illegal");
      step({OP_TRAPI, 26'($urandom())}, $urandom(), 1'b1, 1'b0);
      step({OP_TRAPI, 26'($urandom())}, $urandom(), 1'b0, 1'b0);
      step(wx(OP_GRP31, XO_TW), $urandom(), 1'b1, 1'b0);
      step({OP_SYSC, 26'h0000002}, $urandom(), 1'b0, 1'b0);
      step({OP_FPD, 26'($urandom())}, $urandom(), 1'b0, 1'b0);
      step({OP_FLS_LO, 26'($urandom())}, $urandom(), 1'b0, 1'b0);
      end_test("trap_sc_fp");
      // Wait for a pending higher interrupt, then for the drain
      @(posedge sys_clk);
      hi_irq_pend <= 1'b1;
      offer({OP_SYSC, 26'h0000002}, 32'h0, 1'b0);
      quiet(6);
      @(posedge sys_clk);
      hi_irq_pend <= 1'b0;
      result({OP_SYSC, 26'h0000002}, CS_SYSCALL, 20);
      step(plain(), $urandom(), 1'b0, 1'b1);
      offer({OP_SYSC, 26'h0000002}, 32'h0, 1'b0);
      quiet(6);
      done_pulse(4'h0);
      result({OP_SYSC, 26'h0000002}, CS_SYSCALL, 20);
      end_test("syscall_wait");
      // State write does not switch context until the fetch barrier
      step(wx(OP_GRP31, XO_MTMSR), 32'h0000_6800, 1'b0, 1'b0);
      step(wx(OP_GRP31, XO_MFMSR), $urandom(), 1'b0, 1'b0);
      step(wx(OP_GRP19, XO_ISYNC), $urandom(), 1'b0, 1'b0);
      for (int i = 0; i < 14; i++) begin
         r = (i < 11) ? wx(OP_GRP31, pxo[i]) : (i == 11) ? wx(OP_GRP19, XO_RFI) :
             (i == 12) ? wx(OP_GRP31, XO_MFSPR) | 32'h0010_0000 :
             wx(OP_GRP31, XO_MTSPR) | 32'h0010_0000;
         step(r, $urandom(), 1'b0, 1'b0);
         step(wx(OP_GRP19, XO_RFI), $urandom(), 1'b0, 1'b0);
      end
      step(wx(OP_GRP31, XO_MFSPR), $urandom(), 1'b0, 1'b0);
      end_test("privilege");
      step({OP_FPS, 26'($urandom())}, $urandom(), 1'b0, 1'b1);
      done_pulse(4'h1);
      result(32'h0, CS_FP_EXC, 3);
      for (int i = 0; i < 4; i++) begin
         step(plain(), $urandom(), 1'b0, 1'b1);
         done_pulse(fl[i]);
         result(32'h0, fc[i], 3);
      end
      end_test("completion_faults");
      step(plain(), $urandom(), 1'b0, 1'b1);
      offer(wx(OP_GRP31, XO_SYNC), 32'h0, 1'b0);
      result(wx(OP_GRP31, XO_SYNC), CS_NONE, 4);
      repeat (3) begin
         @(negedge sys_clk);
         chk("drain_ready", issue_ready, 1'b0);
      end
      repeat (2) done_pulse(4'h0);
      step(plain(), $urandom(), 1'b0, 1'b1);
      offer(32'h0000_0000, 32'h0, 1'b0);
      quiet(3);
      done_pulse(4'h4);
      result(32'h0, CS_ALIGN, 3);
      quiet(6);
      end_test("ordering");
      complete_run();
   end
endmodule : tb_csd_dispatch

// [hw/csd_decode.sv]
/* Instruction classifier: turns one instruction word into class bits.
   Purely combinational; the caller registers the result. */
`timescale 1ns/100ps
module csd_decode (
   input  wire logic [31:0]           word, // Instruction word
   output      logic [csd_pkg::CLW-1:0] cls   // Class bits
);
   import csd_pkg::*;
   logic [5:0] opc;
   logic [9:0] xo;
   logic [9:0] srn;

   always_comb begin
      opc = word[OPC_LSB +: 6];
      xo  = word[XO_LSB +: 10];
      srn = {word[15:11], word[20:16]};
      cls = '0;
      cls[CL_ILL]  = (word == 32'h0000_0000) || OP_ILL_MASK[opc];
      cls[CL_SC]   = (opc == OP_SYSC);
      cls[CL_TRAP] = (opc == OP_TRAPI) || (opc == OP_GRP31 && xo == XO_TW);
      cls[CL_FP]   = (opc >= OP_FLS_LO && opc <= OP_FLS_HI) ||
                     (opc == OP_FPS) || (opc == OP_FPD);
      if (opc == OP_GRP19) begin
         cls[CL_RFI]   = (xo == XO_RFI);
         cls[CL_ISYNC] = (xo == XO_ISYNC);
         cls[CL_PRIV]  = (xo == XO_RFI);
      end
      if (opc == OP_GRP31) begin
         cls[CL_SYNC]  = (xo == XO_SYNC);
         cls[CL_MTMSR] = (xo == XO_MTMSR);
         case (xo)
            XO_MFMSR, XO_MTMSR, XO_MFSR, XO_MFSRIN, XO_MTSRIN, XO_DCBI, XO_ICBT,
            XO_TLBIE, XO_TLBSYNC, XO_TLBLD, XO_TLBLI: cls[CL_PRIV] = 1'b1;
            XO_MFSPR, XO_MTSPR: cls[CL_PRIV] = srn[SRN_PRIV_BIT];
            default: cls[CL_PRIV] = 1'b0;
         endcase
      end
   end
endmodule : csd_decode

// [hw/csd_dispatch.sv]
/* Synchronization and instruction-caused exception dispatch for a 32-bit
   core. One-entry hold stage between issue and execution; tracks earlier
   dispatched instructions until they report completion.
   Assumes issue and completion ports run on sys_clk and that completion
   reports arrive in program order. */
`timescale 1ns/100ps
// Functional notes
// - system call and interrupt return wait for all earlier instructions to complete.
// - system call waits while a higher priority interrupt is pending.
// - context sync waits until earlier instructions can no longer fault.
// - earlier instructions keep the context in force when dispatched.
// - instructions after system call or return run in the new context.
// - sync barriers dispatch at once but finish only after earlier ones complete.
// - state-register write waits drained but does not change active context.
// - illegal instruction raises the illegal program exception.
// - supervisor-only instruction in user mode raises privileged exception.
// - special register privilege comes from the register number.
// - page fault goes to the instruction storage fault handler.
// - misaligned access goes to the alignment handler.
// - system call always raises the system call exception.
// - trap instruction with its trap condition true raises the trap program exception.
// - float op with float disabled or absent raises unavailable exception.
// - enabled float exception raises the program exception.
// - illegal instruction changes nothing but exception entry.
// - all-zero word is always illegal.
module csd_dispatch (
   input  wire logic                 sys_clk,         // Core clock
   input  wire logic                 srst,            // Sync reset, high
   input  wire logic                 issue_valid,     // Instruction offered
   input  wire logic [31:0]          issue_word,      // Instruction word
   input  wire logic [31:0]          issue_operand,   // Source operand word
   input  wire logic                 issue_trap_cond, // Trap condition true
   input  wire logic                 hi_irq_pend,     // Higher interrupt pending
   input  wire logic                 done_valid,      // Oldest in flight done
   input  wire logic                 done_page_fault, // It hit a page fault
   input  wire logic                 done_align_fault,// It was misaligned
   input  wire logic                 done_dstore_err, // Direct-store error
   input  wire logic                 done_fp_exc,     // Float exception raised
   output      logic                 issue_ready,     // Hold stage free
   output      logic                 exec_valid,      // Dispatch pulse
   output      logic [31:0]          exec_word,       // Dispatched word
   output      logic                 exc_valid,       // Exception pulse
   output      csd_pkg::csd_cause_t  exc_cause,       // Exception cause
   output      logic                 flush,           // Discard younger work
   output      logic                 user_mode_bit,   // Active user context
   output      logic [2:0]           machine_state_reg // Written state bits
);
   import csd_pkg::*;

   typedef struct packed {
      csd_state_t       state;
      logic             hold_v;
      logic [CLW-1:0]   hold_cls;
      logic [31:0]      hold_word;
      logic [2:0]       hold_wst;
      logic             hold_trap;
      logic [3:0]       inflight;
      logic [2:0]       wst;
      logic [2:0]       ctx;
      logic [2:0]       saved;
      logic             ready;
      logic             exec_v;
      logic [31:0]      exec_word;
      logic             exc_v;
      csd_cause_t       cause;
      logic             flush;
   } csd_regs_t;

   localparam csd_regs_t R_RST = '{state: ST_RUN, wst: WST_RST, ctx: WST_RST,
                                   saved: WST_RST, cause: CS_NONE, default: '0};

   csd_regs_t      r;
   csd_regs_t      next_r;
   logic [CLW-1:0] dec_cls;
   logic [CLW-1:0] c;
   logic           take;
   logic           dfault;
   csd_cause_t     dcause;
   csd_cause_t     hcause;
   logic           drained;
   logic           need_drain;
   logic           hfire;
   logic           fire_rfi;
   logic           fire_mtmsr;
   logic           inc;

   csd_decode u_decode (
      .word (issue_word),
      .cls  (dec_cls)
   );

   always_comb begin
      next_r          = r;
      next_r.exec_v   = 1'b0;
      next_r.exc_v    = 1'b0;
      next_r.flush    = 1'b0;
      c               = r.hold_cls;
      take            = issue_valid && r.ready;
      inc             = 1'b0;
      fire_rfi        = 1'b0;
      fire_mtmsr      = 1'b0;
      drained         = (r.inflight == 4'h0);
      dcause = CS_NONE;
      if (done_page_fault) begin
         dcause = CS_ISF;
      end else if (done_align_fault) begin
         dcause = CS_ALIGN;
      end else if (done_dstore_err) begin
         dcause = CS_DSTORE;
      end else if (done_fp_exc && r.ctx[M_FE]) begin
         dcause = CS_FP_EXC;
      end
      dfault = done_valid && (dcause != CS_NONE);
      hcause = CS_NONE;
      if (c[CL_ILL]) begin
         hcause = CS_ILLEGAL;
      end else if (c[CL_PRIV] && r.ctx[M_PR]) begin
         hcause = CS_PRIV;
      end else if (c[CL_FP] && !(r.ctx[M_FP] && FP_PRESENT)) begin
         hcause = CS_FP_UNAVAIL;
      end else if (c[CL_TRAP] && r.hold_trap) begin
         hcause = CS_TRAP;
      end else if (c[CL_SC]) begin
         hcause = CS_SYSCALL;
      end
      need_drain = (hcause != CS_NONE) || c[CL_RFI] || c[CL_MTMSR];
      hfire = (r.state == ST_RUN) && r.hold_v && !dfault && need_drain &&
              drained && !(c[CL_SC] && hi_irq_pend);

      case (r.state)
         ST_RUN: begin
            if (dfault) begin
               next_r.exc_v  = 1'b1;
               next_r.cause  = dcause;
               next_r.hold_v = 1'b0;
            end else if (r.hold_v) begin
               if (c[CL_SYNC] || c[CL_ISYNC]) begin
                  next_r.exec_v    = 1'b1;
                  next_r.exec_word = r.hold_word;
                  next_r.hold_v    = 1'b0;
                  next_r.state     = ST_DRAIN;
               end else if (!need_drain) begin
                  next_r.exec_v    = 1'b1;
                  next_r.exec_word = r.hold_word;
                  next_r.hold_v    = 1'b0;
                  inc              = 1'b1;
               end else if (hfire) begin
                  next_r.hold_v = 1'b0;
                  if (hcause != CS_NONE) begin
                     next_r.exc_v = 1'b1;
                     next_r.cause = hcause;
                  end else if (c[CL_RFI]) begin
                     fire_rfi         = 1'b1;
                     next_r.wst       = r.saved;
                     next_r.ctx       = r.saved;
                     next_r.exec_v    = 1'b1;
                     next_r.exec_word = r.hold_word;
                  end else begin
                     fire_mtmsr       = 1'b1;
                     next_r.wst       = r.hold_wst;
                     next_r.exec_v    = 1'b1;
                     next_r.exec_word = r.hold_word;
                  end
               end
            end
         end
         ST_DRAIN: begin
            if (dfault) begin
               next_r.exc_v = 1'b1;
               next_r.cause = dcause;
               next_r.state = ST_RUN;
            end else if (drained) begin
               next_r.state = ST_RUN;
               if (r.hold_cls[CL_ISYNC]) begin
                  next_r.ctx = r.wst;
               end
            end
         end
         default: begin
            next_r.state = ST_RUN;
         end
      endcase

      if (next_r.exc_v) begin
         next_r.flush     = 1'b1;
         next_r.saved     = r.wst;
         next_r.wst[M_PR] = 1'b0;
         next_r.ctx       = next_r.wst;
         next_r.inflight  = 4'h0;
      end else begin
         next_r.inflight = r.inflight - {3'h0, done_valid && !drained} + {3'h0, inc};
      end

      // Issue taken alongside a flush is younger and is discarded
      if (take && !next_r.exc_v) begin
         next_r.hold_v    = 1'b1;
         next_r.hold_cls  = dec_cls;
         next_r.hold_word = issue_word;
         next_r.hold_trap = issue_trap_cond;
         next_r.hold_wst  = {issue_operand[OPND_PR_POS], issue_operand[OPND_FP_POS],
                             issue_operand[OPND_FE0_POS] | issue_operand[OPND_FE1_POS]};
      end
      next_r.ready = !next_r.hold_v && (next_r.state == ST_RUN) &&
                     (next_r.inflight != INFL_MAX);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         r <= R_RST;
      end else begin
         r <= next_r;
      end
   end

   assign issue_ready       = r.ready;
   assign exec_valid        = r.exec_v;
   assign exec_word         = r.exec_word;
   assign exc_valid         = r.exc_v;
   assign exc_cause         = r.cause;
   assign flush             = r.flush;
   assign user_mode_bit     = r.ctx[M_PR];
   assign machine_state_reg = r.wst;

   // Checks
   logic [3:0] infl;
   logic [2:0] ctx_q;
   logic [2:0] wst_q;
   csd_state_t st_q;
   assign infl  = r.inflight;
   assign ctx_q = r.ctx;
   assign wst_q = r.wst;
   assign st_q  = r.state;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   a_sc_after_drain: assert property (
      exc_valid && exc_cause == CS_SYSCALL |-> $past(infl) == 4'h0)
      else $error("system call raised with work in flight");

   a_sc_no_higher: assert property (
      exc_valid && exc_cause == CS_SYSCALL |-> !$past(hi_irq_pend))
      else $error("system call taken with higher interrupt pending");

   a_state_write_drained: assert property (
      $changed(wst_q) && !exc_valid |-> $past(infl) == 4'h0)
      else $error("state changed before earlier work completed");

   a_ctx_change_point: assert property (
      $changed(ctx_q) |-> exc_valid || $past(st_q) == ST_DRAIN || $past(fire_rfi))
      else $error("context changed outside a sync point");

   a_rfi_new_ctx: assert property (
      fire_rfi |=> ctx_q == wst_q && exec_valid)
      else $error("return did not establish new context");

   a_barrier_blocks: assert property (
      st_q == ST_DRAIN |-> !issue_ready)
      else $error("issue open while barrier drains");

   a_barrier_ends: assert property (
      st_q == ST_DRAIN && infl == 4'h0 && !done_valid |=> st_q == ST_RUN)
      else $error("barrier did not complete once drained");

   a_mtmsr_keeps_ctx: assert property (
      fire_mtmsr |=> $stable(ctx_q) ##1 $stable(ctx_q) || exc_valid)
      else $error("state write changed active context");

   a_illegal_cause: assert property (
      hfire && c[CL_ILL] |=> exc_valid && exc_cause == CS_ILLEGAL && flush)
      else $error("illegal word not raised as illegal");

   a_priv_user: assert property (
      hfire && !c[CL_ILL] && c[CL_PRIV] && ctx_q[M_PR] |=> exc_cause == CS_PRIV)
      else $error("privileged op in user mode not raised");

   a_regnum_privilege: assert property (
      r.hold_v && r.hold_word[31:26] == OP_GRP31 && r.hold_word[10:1] == XO_MFSPR &&
      !r.hold_word[20] |-> !r.hold_cls[CL_PRIV])
      else $error("user register read marked privileged");

   a_page_fault: assert property (
      done_valid && done_page_fault |=> exc_valid && exc_cause == CS_ISF)
      else $error("page fault not sent to storage handler");

   a_align_fault: assert property (
      done_valid && !done_page_fault && done_align_fault |=> exc_cause == CS_ALIGN)
      else $error("misalignment not sent to alignment handler");

   a_sc_always: assert property (
      hfire && hcause == CS_SYSCALL |=> exc_valid && exc_cause == CS_SYSCALL)
      else $error("system call did not raise");

   a_trap_taken: assert property (
      hfire && hcause == CS_TRAP |=> exc_valid && exc_cause == CS_TRAP)
      else $error("trap not raised");

   a_fp_unavail: assert property (
      hfire && !c[CL_ILL] && !c[CL_PRIV] && c[CL_FP] && !ctx_q[M_FP]
      |=> exc_cause == CS_FP_UNAVAIL)
      else $error("float op with float off not raised");

   a_fp_exc: assert property (
      done_valid && done_fp_exc && ctx_q[M_FE] |=> exc_valid)
      else $error("enabled float exception not raised");

   a_ill_no_state: assert property (
      hfire && c[CL_ILL] |=> !exec_valid && wst_q[M_FP:0] == $past(wst_q[M_FP:0]))
      else $error("illegal op changed state");

   a_zero_illegal: assert property (
      r.hold_v && r.hold_word == 32'h0000_0000 |-> r.hold_cls[CL_ILL])
      else $error("zero word not decoded illegal");

   a_older_first: assert property (
      dfault |=> flush && !exec_valid && !r.hold_v && infl == 4'h0)
      else $error("younger work survived older fault");

   c_syscall: cover property (hfire && c[CL_SC]);
   c_barrier: cover property (st_q == ST_DRAIN ##1 st_q == ST_RUN);
   c_rfi:     cover property (fire_rfi);
   c_race:    cover property (dfault && r.hold_v);
endmodule : csd_dispatch

// [hw/csd_pkg.sv]
/* Constants for the core sync and exception dispatch block: opcode fields,
   instruction classes, local machine-state layout, causes and states.
   Assumes 32-bit instruction words with the primary opcode in bits 31:26. */
package csd_pkg;
   // Field positions in the instruction word
   localparam int OPC_LSB = 26;
   localparam int XO_LSB  = 1;
   // Primary opcodes
   localparam logic [5:0] OP_TRAPI  = 6'h03;
   localparam logic [5:0] OP_SYSC   = 6'h11;
   localparam logic [5:0] OP_GRP19  = 6'h13;
   localparam logic [5:0] OP_GRP31  = 6'h1F;
   localparam logic [5:0] OP_FLS_LO = 6'h30;
   localparam logic [5:0] OP_FLS_HI = 6'h37;
   localparam logic [5:0] OP_FPS    = 6'h3B;
   localparam logic [5:0] OP_FPD    = 6'h3F;
   // Primary opcodes that carry no instruction on this core
   localparam logic [63:0] OP_ILL_MASK = 64'h7700_0000_4000_0077;
   // Extended opcodes
   localparam logic [9:0] XO_TW      = 10'h004;
   localparam logic [9:0] XO_ICBT    = 10'h016;
   localparam logic [9:0] XO_RFI     = 10'h032;
   localparam logic [9:0] XO_MFMSR   = 10'h053;
   localparam logic [9:0] XO_MTMSR   = 10'h092;
   localparam logic [9:0] XO_ISYNC   = 10'h096;
   localparam logic [9:0] XO_MTSRIN  = 10'h0F2;
   localparam logic [9:0] XO_TLBIE   = 10'h132;
   localparam logic [9:0] XO_MFSPR   = 10'h153;
   localparam logic [9:0] XO_MTSPR   = 10'h1D3;
   localparam logic [9:0] XO_DCBI    = 10'h1D6;
   localparam logic [9:0] XO_TLBSYNC = 10'h236;
   localparam logic [9:0] XO_MFSR    = 10'h253;
   localparam logic [9:0] XO_SYNC    = 10'h256;
   localparam logic [9:0] XO_MFSRIN  = 10'h293;
   localparam logic [9:0] XO_TLBLD   = 10'h3D2;
   localparam logic [9:0] XO_TLBLI   = 10'h3F2;
   // Privileged bit of the swapped-halves special register number
   localparam int SRN_PRIV_BIT = 4;
   // Machine-state bits inside a 32-bit operand word
   localparam int OPND_PR_POS  = 14;
   localparam int OPND_FP_POS  = 13;
   localparam int OPND_FE0_POS = 11;
   localparam int OPND_FE1_POS = 8;
   // Local 3-bit machine state: user, fp enable, fp exception enable
   localparam int M_PR = 2;
   localparam int M_FP = 1;
   localparam int M_FE = 0;
   localparam logic [2:0] WST_RST    = 3'h0;
   localparam logic       FP_PRESENT = 1'b1;
   localparam logic [3:0] INFL_MAX   = 4'hF;
   // Instruction class bits
   localparam int CL_ILL   = 0;
   localparam int CL_PRIV  = 1;
   localparam int CL_FP    = 2;
   localparam int CL_TRAP  = 3;
   localparam int CL_SC    = 4;
   localparam int CL_RFI   = 5;
   localparam int CL_ISYNC = 6;
   localparam int CL_SYNC  = 7;
   localparam int CL_MTMSR = 8;
   localparam int CLW      = 9;
   typedef enum logic [3:0] {
      CS_NONE = 4'h0, CS_ILLEGAL = 4'h1, CS_PRIV = 4'h2, CS_ISF = 4'h3,
      CS_ALIGN = 4'h4, CS_SYSCALL = 4'h5, CS_TRAP = 4'h6,
      CS_FP_UNAVAIL = 4'h7, CS_FP_EXC = 4'h8, CS_DSTORE = 4'h9
   } csd_cause_t;
   typedef enum logic [1:0] {ST_RUN = 2'h1, ST_DRAIN = 2'h2} csd_state_t;
endpackage : csd_pkg
